// ===== rtl/asrw_receiver.sv
`timescale 1ns/1ps
module asrw_receiver
	import asrw_pkg::*;
#(
	parameter int DIV_W = 16
)(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        rxLine,
	input  wire logic        sleepMode,
	output logic             irqHigh,
	output logic             irqLow
);
	if (DIV_W != 16)
	begin : g_chk
		$error("asrw_receiver: divisor is two 8-bit registers, DIV_W must be 16");
	end

	asrw_state_t state_r;
	logic [7:0]  rxCtl_r;
	logic [7:0]  txCtl_r;
	logic [7:0]  baudCtl_r;
	logic        wakeEn_r;
	logic [7:0]  divHi_r;
	logic [7:0]  divLo_r;
	logic [7:0]  txBuf_r;
	logic [1:0]  intCtl_r;
	logic [7:0]  rxBuf_r;
	logic        ninth_r;
	logic        frameErr_r;
	logic        ovrnErr_r;
	logic        bufFull_r;
	logic        wakePend_r;
	logic        wakeSeen_r;
	logic        rxMeta_r;
	logic        rxSync_r;
	logic        rxPrev_r;
	logic [2:0]  hist_r;
	logic [3:0]  smpCnt_r;
	logic [3:0]  bitCnt_r;
	logic [8:0]  shift_r;
	logic        wrPend_r;
	logic [7:0]  wrAddr_r;
	logic [31:0] hrdata_r;

	logic        asyncOn;
	logic        rxActive;
	logic        tick16;
	logic        maj;
	logic [3:0]  nBits;
	logic        doneNow;
	logic [7:0]  doneData;
	logic        doneNinth;
	logic        accept;
	logic        addrPhase;
	logic        busRead;
	logic        bufRead;
	logic        wrEn;
	logic [7:0]  wrByte;
	logic        wakeFall;
	logic        wakeRise;
	logic        rcFlag;
	logic [7:0]  rdMux;
	logic [7:0]  baudView;
	logic [7:0]  rxView;

	// asynchronous operation and wake-up monitoring gate
	assign asyncOn  = rxCtl_r[RXC_PORT_EN] && !txCtl_r[TXC_SYNC];
	// reception allowed only when enabled, awake, not blocked
	assign rxActive = asyncOn && rxCtl_r[RXC_CONT_EN] && !sleepMode
		&& !wakeEn_r && !ovrnErr_r;

	// generator stops in sleep, x64 only when both selects clear
	asrw_baud_gen #(
		.DIV_W   (DIV_W)
	) u_baud (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.run     (asyncOn && !sleepMode),
		.divisor (baudCtl_r[BDC_DIV16] ? {divHi_r, divLo_r} : {8'h00, divLo_r}),
		.x64     (!txCtl_r[TXC_HI_SPEED] && !baudCtl_r[BDC_DIV16]),
		.tick16  (tick16)
	);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxMeta_r <= 1'b1;
			rxSync_r <= 1'b1;
			rxPrev_r <= 1'b1;
		end
		else
		begin
			rxMeta_r <= rxLine;
			rxSync_r <= rxMeta_r;
			rxPrev_r <= rxSync_r;
		end
	end

	// Three-sample majority rejects a single glitch near the bit centre.
	assign maj = (hist_r[1] & hist_r[0]) | (hist_r[1] & rxSync_r) | (hist_r[0] & rxSync_r);
	// nine-bit select sets the data bit count
	assign nBits = rxCtl_r[RXC_NINE_SEL] ? BITS_NINE : BITS_EIGHT;

	// history of x16 samples feeds the bit decision
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			hist_r <= 3'h7;
		else if (tick16)
			hist_r <= {hist_r[1:0], rxSync_r};
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r  <= ST_IDLE;
			smpCnt_r <= '0;
			bitCnt_r <= '0;
			shift_r  <= '0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					smpCnt_r <= '0;
					bitCnt_r <= '0;
					// wake-up enable holds the receiver out of reception
					if (wakeEn_r && asyncOn)
						state_r <= ST_WAKE;
					// start on a high-to-low between two x16 samples
					else if (rxActive && tick16 && hist_r[0] && !rxSync_r)
						state_r <= ST_START;
				end
				ST_START:
				begin
					if (!rxActive)
						state_r <= ST_IDLE;
					else if (tick16)
					begin
						if (smpCnt_r == SMP_START_MID)
						begin
							smpCnt_r <= '0;
							state_r  <= maj ? ST_IDLE : ST_DATA;
						end
						else
							smpCnt_r <= smpCnt_r + 1'b1;
					end
				end
				ST_DATA:
				begin
					if (!rxActive)
						state_r <= ST_IDLE;
					else if (tick16)
					begin
						smpCnt_r <= smpCnt_r + 1'b1;
						// one shift per bit time, LSB first
						if (smpCnt_r == SMP_LAST)
						begin
							shift_r  <= {maj, shift_r[8:1]};
							bitCnt_r <= bitCnt_r + 1'b1;
							if (bitCnt_r == nBits - 1'b1)
								state_r <= ST_STOP;
						end
					end
				end
				ST_STOP:
				begin
					if (!rxActive)
						state_r <= ST_IDLE;
					else if (tick16)
					begin
						smpCnt_r <= smpCnt_r + 1'b1;
						if (smpCnt_r == SMP_LAST)
							state_r <= ST_IDLE;
					end
				end
				ST_WAKE:
				begin
					if (!(wakeEn_r && asyncOn))
						state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	assign doneNow = (state_r == ST_STOP) && rxActive && tick16 && (smpCnt_r == SMP_LAST);
	// an 8-bit frame leaves the data one place higher in the shifter
	assign doneData  = rxCtl_r[RXC_NINE_SEL] ? shift_r[7:0] : shift_r[8:1];
	assign doneNinth = rxCtl_r[RXC_NINE_SEL] & shift_r[8];
	// in nine-bit mode, address detect passes only characters with the ninth bit set
	assign accept = !(rxCtl_r[RXC_NINE_SEL] && rxCtl_r[RXC_ADDR_DET] && !doneNinth);

	// falling edge while monitoring; watched on mclk so it works in sleep
	assign wakeFall = (state_r == ST_WAKE) && !wakeSeen_r && rxPrev_r && !rxSync_r;
	// first rising edge after the event ends the wake-up
	assign wakeRise = (state_r == ST_WAKE) && wakeSeen_r && !rxPrev_r && rxSync_r;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			wakeSeen_r <= 1'b0;
		else if (state_r != ST_WAKE || wakeRise)
			wakeSeen_r <= 1'b0;
		else if (wakeFall)
			wakeSeen_r <= 1'b1;
	end

	// Bus slave: zero wait states, address captured for the write data phase.
	assign addrPhase = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
	assign busRead   = addrPhase && !hwrite;
	assign bufRead   = busRead && (haddr[7:0] == OFS_RXBUF) && (haddr[31:8] == '0);
	assign wrEn      = wrPend_r;
	assign wrByte    = hwdata[7:0];

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wrPend_r <= 1'b0;
			wrAddr_r <= '0;
		end
		else
		begin
			wrPend_r <= addrPhase && hwrite && (haddr[31:8] == '0);
			wrAddr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxCtl_r   <= BYTE_RST;
			txCtl_r   <= BYTE_RST;
			baudCtl_r <= BYTE_RST;
			divHi_r   <= BYTE_RST;
			divLo_r   <= BYTE_RST;
			txBuf_r   <= BYTE_RST;
			intCtl_r  <= '0;
		end
		else if (wrEn)
		begin
			if (wrAddr_r == OFS_RXCTL)
				rxCtl_r <= wrByte;
			else if (wrAddr_r == OFS_TXCTL)
				txCtl_r <= wrByte;
			else if (wrAddr_r == OFS_BAUD)
				baudCtl_r <= wrByte & BAUD_STORE_MSK;
			else if (wrAddr_r == OFS_DIVHI)
				divHi_r <= wrByte;
			else if (wrAddr_r == OFS_DIVLO)
				divLo_r <= wrByte;
			else if (wrAddr_r == OFS_TXBUF)
				txBuf_r <= wrByte;
			else if (wrAddr_r == OFS_INTCTL)
				intCtl_r <= {wrByte[INT_PRIO], wrByte[INT_ENABLE]};
		end
	end

	// Software may rewrite wake-up enable; otherwise hardware clears it.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			wakeEn_r <= 1'b0;
		else if (wrEn && wrAddr_r == OFS_BAUD)
			wakeEn_r <= wrByte[BDC_WAKE_EN];
		else if (wakeRise)
			wakeEn_r <= 1'b0;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxBuf_r    <= '0;
			ninth_r    <= 1'b0;
			frameErr_r <= 1'b0;
			ovrnErr_r  <= 1'b0;
			bufFull_r  <= 1'b0;
		end
		else
		begin
			// a new character into an unread buffer is lost and blocks
			if (doneNow && accept && bufFull_r)
				ovrnErr_r <= 1'b1;
			// clearing continuous receive clears latched errors
			else if (!rxCtl_r[RXC_CONT_EN])
				ovrnErr_r <= 1'b0;
			// load the buffer, set flag, latch the stop-bit error
			if (doneNow && accept && !bufFull_r)
			begin
				rxBuf_r    <= doneData;
				ninth_r    <= doneNinth;
				frameErr_r <= !maj;
				bufFull_r  <= 1'b1;
			end
			else
			begin
				if (!rxCtl_r[RXC_CONT_EN])
					frameErr_r <= 1'b0;
				if (bufRead)
					bufFull_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			wakePend_r <= 1'b0;
		// wake-up event raises the receive flag; set wins over clear
		else if (wakeFall)
			wakePend_r <= 1'b1;
		// buffer read drops the wake-up condition
		else if (bufRead)
			wakePend_r <= 1'b0;
	end

	// one receive flag for data and wake-up
	assign rcFlag = bufFull_r || wakePend_r;

	// error and ninth-bit view over the stored control bits
	assign rxView = {rxCtl_r[7:3], frameErr_r, ovrnErr_r, ninth_r};
	// unimplemented bits zero, idle bit from the receiver state
	assign baudView = baudCtl_r
		| ({7'h00, wakeEn_r} << BDC_WAKE_EN)
		| ({7'h00, state_r == ST_IDLE || state_r == ST_WAKE} << BDC_RX_IDLE);

	always_comb
	begin
		rdMux = BYTE_RST;
		if (haddr[31:8] != '0)
			rdMux = BYTE_RST;
		else if (haddr[7:0] == OFS_RXCTL)
			rdMux = rxView;
		else if (haddr[7:0] == OFS_TXCTL)
			rdMux = txCtl_r | ({7'h00, 1'b1} << TXC_SR_EMPTY);
		else if (haddr[7:0] == OFS_BAUD)
			rdMux = baudView;
		else if (haddr[7:0] == OFS_DIVHI)
			rdMux = divHi_r;
		else if (haddr[7:0] == OFS_DIVLO)
			rdMux = divLo_r;
		// buffer read gives the eight low data bits
		else if (haddr[7:0] == OFS_RXBUF)
			rdMux = rxBuf_r;
		else if (haddr[7:0] == OFS_TXBUF)
			rdMux = txBuf_r;
		else if (haddr[7:0] == OFS_INTCTL)
			rdMux = {5'h00, rcFlag, intCtl_r};
	end

	// Read data is latched at the address edge so it stands for the data phase.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			hrdata_r <= '0;
		else if (busRead)
			hrdata_r <= {24'h000000, rdMux};
	end

	assign hrdata    = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// enabled flag routed by priority bit
	assign irqHigh = rcFlag && intCtl_r[INT_ENABLE] && intCtl_r[INT_PRIO];
	assign irqLow  = rcFlag && intCtl_r[INT_ENABLE] && !intCtl_r[INT_PRIO];
endmodule // asrw_receiver

// ===== inc/asrw_pkg.sv
package asrw_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0] OFS_RXCTL  = 8'h00;
	localparam logic [7:0] OFS_TXCTL  = 8'h04;
	localparam logic [7:0] OFS_BAUD   = 8'h08;
	localparam logic [7:0] OFS_DIVHI  = 8'h0C;
	localparam logic [7:0] OFS_DIVLO  = 8'h10;
	localparam logic [7:0] OFS_RXBUF  = 8'h14;
	localparam logic [7:0] OFS_TXBUF  = 8'h18;
	localparam logic [7:0] OFS_INTCTL = 8'h1C;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// receive_status_control fields.
	localparam int RXC_PORT_EN   = 7;
	localparam int RXC_NINE_SEL  = 6;
	localparam int RXC_SINGLE_EN = 5;
	localparam int RXC_CONT_EN   = 4;
	localparam int RXC_ADDR_DET  = 3;
	localparam int RXC_FRAME_ERR = 2;
	localparam int RXC_OVRN_ERR  = 1;
	localparam int RXC_NINTH     = 0;
	// transmit_status_control fields.
	localparam int TXC_SYNC      = 4;
	localparam int TXC_HI_SPEED  = 2;
	localparam int TXC_SR_EMPTY  = 1;
	// baud_control fields.
	localparam int BDC_ABD_OVF   = 7;
	localparam int BDC_RX_IDLE   = 6;
	localparam int BDC_CLK_POL   = 4;
	localparam int BDC_DIV16     = 3;
	localparam int BDC_WAKE_EN   = 1;
	localparam int BDC_ABD_EN    = 0;
	// Interrupt control fields.
	localparam int INT_ENABLE    = 0;
	localparam int INT_PRIO      = 1;
	localparam int INT_FLAG      = 2;

	localparam logic [7:0] BYTE_RST      = 8'h00;
	localparam logic [7:0] BAUD_STORE_MSK = 8'h99;

	// Recovery timing in ticks of the x16 sampling clock, the x64 prescale count and data bit counts.
	localparam logic [3:0] SMP_START_MID = 4'h7;
	localparam logic [3:0] SMP_LAST      = 4'hF;
	localparam logic [1:0] PRE64_LAST    = 2'h3;
	localparam logic [3:0] BITS_EIGHT    = 4'h8;
	localparam logic [3:0] BITS_NINE     = 4'h9;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_START = 5'b00010,
		ST_DATA  = 5'b00100,
		ST_STOP  = 5'b01000,
		ST_WAKE  = 5'b10000
	} asrw_state_t;
endpackage

// ===== rtl/asrw_baud_gen.sv
`timescale 1ns/1ps
module asrw_baud_gen
	import asrw_pkg::*;
#(
	parameter int DIV_W = 16
)(
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic             x64,
	output logic                  tick16
);
	logic [DIV_W-1:0] cnt_r;
	logic [1:0]       pre_r;
	logic             brgTick;

	if (DIV_W < 8)
	begin : g_chk
		$error("asrw_baud_gen: DIV_W must be at least 8");
	end

	assign brgTick = run && (cnt_r == '0);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			cnt_r <= '0;
		else if (!run || brgTick)
			cnt_r <= divisor;
		else
			cnt_r <= cnt_r - 1'b1;
	end

	// In the x64 setting every fourth generator tick becomes one x16 sample.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			pre_r <= '0;
		else if (!run)
			pre_r <= '0;
		else if (brgTick)
			pre_r <= pre_r + 1'b1;
	end

	assign tick16 = brgTick && (!x64 || pre_r == PRE64_LAST);
endmodule // asrw_baud_gen

// ===== verif/asrw_props.sv
`timescale 1ns/1ps
module asrw_props
	import asrw_pkg::*;
#(
	parameter int DIV_W = 16
)(
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        rxLine,
	input wire logic        sleepMode,
	input wire logic        irqHigh,
	input wire logic        irqLow
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	logic busy;
	logic rdAcc;
	assign busy  = hsel && hready && htrans[1];
	assign rdAcc = busy && !hwrite && hsize == HSIZE_WORD;

	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_irq_exclusive: assert property (!(irqHigh && irqLow))
		else $error("both interrupt lines high");
	a_read_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_baud_reserved: assert property (rdAcc && haddr == {24'h0, OFS_BAUD} |=>
		!hrdata[5] && !hrdata[2])
		else $error("unused baud control bits read as one");
	a_unmapped_zero: assert property (rdAcc && haddr == 32'h0000_0020 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_read_stands: assert property (!rdAcc |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_txctl_empty: assert property (rdAcc && haddr == {24'h0, OFS_TXCTL} |=>
		hrdata[TXC_SR_EMPTY])
		else $error("shift register empty bit low");
	// A pending flag may only fall after a bus access has had time to land.
	a_irq_holds: assert property ((irqHigh || irqLow) && !busy && !$past(busy) |=>
		irqHigh || irqLow)
		else $error("interrupt dropped without an access");

	c_irq_high: cover property ($rose(irqHigh));
	c_irq_low: cover property ($rose(irqLow));
	c_buf_read: cover property (rdAcc && haddr == {24'h0, OFS_RXBUF});
endmodule // asrw_props

bind asrw_receiver asrw_props #(.DIV_W(DIV_W)) uProps (.mclk(mclk), .arst_n(arst_n),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .rxLine(rxLine), .sleepMode(sleepMode), .irqHigh(irqHigh),
	.irqLow(irqLow));

// ===== verif/asrw_line_model.sv
`timescale 1ns/1ps
module asrw_line_model
(
	input wire logic mclk,
	output logic     rxLine
);
	// The line idles high between frames, like a pulled-up receive line.
	initial rxLine = 1'b1;

	// start bit, data least significant first, then the stop level.
	task automatic send(input logic [8:0] d, input int n, input logic stopBit, input int bt);
		rxLine <= 1'b0;
		repeat (bt) @(posedge mclk);
		for (int i = 0; i < n; i++)
		begin
			rxLine <= d[i];
			repeat (bt) @(posedge mclk);
		end
		rxLine <= stopBit;
		repeat (bt) @(posedge mclk);
		rxLine <= 1'b1;
	endtask

	// A break stays low long enough for the receiver to wake.
	task automatic hold_low(input int clks);
		rxLine <= 1'b0;
		repeat (clks) @(posedge mclk);
		rxLine <= 1'b1;
	endtask
endmodule // asrw_line_model

// ===== verif/async_serial_receiver_wakeup_test.sv
`timescale 1ns/1ps
module async_serial_receiver_wakeup_test
	import asrw_pkg::*;
();
	logic        mclk;
	logic        arst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rxLine;
	logic        sleepMode;
	logic        irqHigh;
	logic        irqLow;
	int          failures;
	int          numChecks;
	int          cycles;
	int          bitClks;

	asrw_receiver DUT (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.rxLine(rxLine), .sleepMode(sleepMode), .irqHigh(irqHigh), .irqLow(irqLow));
	asrw_line_model uLine (.mclk(mclk), .rxLine(rxLine));

	always #10 mclk = ~mclk;

	task automatic print_verdict();
		$display("checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic [7:0] a, input logic wrt, input logic [7:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wrt;
		hsize  <= HSIZE_WORD;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge mclk); while (hreadyout !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		bus(a, 1'b0, 8'h00);
		chk(hrdata & m, e & m);
	endtask

	task automatic irq(input logic [1:0] e);
		chk({30'h0, irqHigh, irqLow}, {30'h0, e});
	endtask

	// The flag is given one spare bit time after the stop bit to appear.
	task automatic frame(input logic [8:0] d, input int n, input logic s, input logic [1:0] e);
		uLine.send(d, n, s, bitClks);
		repeat (bitClks) @(posedge mclk);
		irq(e);
	endtask

	initial
	begin
		mclk = 1'b0;
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		sleepMode = 1'b0;
		failures = 0;
		numChecks = 0;
		cycles = 0;
		bitClks = 16;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rd(OFS_RXCTL, 32'h00);
		rd(OFS_TXCTL, 32'h02);
		rd(OFS_BAUD, 32'h40);
		rd(8'h20, 32'h00);
		wr(OFS_BAUD, 8'hFD);
		rd(OFS_BAUD, 32'hD9);
		wr(OFS_BAUD, 8'h00);
		// High speed with divisor zero gives sixteen clocks per bit.
		wr(OFS_TXCTL, 8'h04);
		rd(OFS_TXCTL, 32'h06);
		wr(OFS_DIVLO, 8'h00);
		wr(OFS_INTCTL, 8'h01);
		wr(OFS_RXCTL, 8'h90);
		frame(9'h0A5, 8, 1'b1, 2'b01);
		rd(OFS_INTCTL, 32'h05);
		rd(OFS_RXCTL, 32'h90);
		rd(OFS_RXBUF, 32'hA5);
		irq(2'b00);
		frame(9'h03C, 8, 1'b0, 2'b01);
		rd(OFS_RXCTL, 32'h94);
		rd(OFS_RXBUF, 32'h3C);
		frame(9'h011, 8, 1'b1, 2'b01);
		frame(9'h022, 8, 1'b1, 2'b01);
		rd(OFS_RXCTL, 32'h92);
		rd(OFS_RXBUF, 32'h11);
		frame(9'h033, 8, 1'b1, 2'b00);
		wr(OFS_RXCTL, 8'h80);
		wr(OFS_RXCTL, 8'h90);
		rd(OFS_RXCTL, 32'h90);
		frame(9'h044, 8, 1'b1, 2'b01);
		rd(OFS_RXBUF, 32'h44);
		wr(OFS_INTCTL, 8'h03);
		wr(OFS_RXCTL, 8'hD0);
		frame(9'h155, 9, 1'b1, 2'b10);
		rd(OFS_RXCTL, 32'hD1);
		rd(OFS_RXBUF, 32'h55);
		wr(OFS_RXCTL, 8'hD8);
		frame(9'h0AA, 9, 1'b1, 2'b00);
		frame(9'h1BB, 9, 1'b1, 2'b10);
		rd(OFS_RXBUF, 32'hBB);
		wr(OFS_INTCTL, 8'h01);
		wr(OFS_RXCTL, 8'h80);
		frame(9'h066, 8, 1'b1, 2'b00);
		wr(OFS_RXCTL, 8'h90);
		wr(OFS_TXCTL, 8'h14);
		frame(9'h077, 8, 1'b1, 2'b00);
		// With the port in synchronous mode a falling edge must not wake it.
		wr(OFS_BAUD, 8'h02);
		uLine.hold_low(2 * bitClks);
		repeat (4) @(posedge mclk);
		irq(2'b00);
		wr(OFS_BAUD, 8'h00);
		wr(OFS_TXCTL, 8'h00);
		bitClks = 64;
		frame(9'h099, 8, 1'b1, 2'b01);
		rd(OFS_RXBUF, 32'h99);
		bitClks = 16;
		wr(OFS_TXCTL, 8'h04);
		sleepMode <= 1'b1;
		frame(9'h088, 8, 1'b1, 2'b00);
		wr(OFS_BAUD, 8'h02);
		rd(OFS_BAUD, 32'h42);
		uLine.hold_low(13 * bitClks);
		repeat (4) @(posedge mclk);
		irq(2'b01);
		rd(OFS_BAUD, 32'h40);
		sleepMode <= 1'b0;
		rd(OFS_RXBUF, 32'h0, 32'hFFFF_FF00);
		irq(2'b00);
		frame(9'h0C3, 8, 1'b1, 2'b01);
		rd(OFS_RXBUF, 32'hC3);
		print_verdict();
	end
endmodule // async_serial_receiver_wakeup_test
